// >>> psr_regs.sv
// power supervisor register bank behind a classic wishbone slave
// ==================================================================
// How it works
// - bus power arrival sets its event flag to 1.
// - bus power loss sets the flag at 0x120.
// - usb regulator settled sets the flag at 0x124.
// - writing 1 at 0x304 sets event enables; reads return enables.
// - writing 1 at 0x308 clears event enables; reads return enables.
// - reset cause flags accumulate across resets until software clears them.
// - writing 1 clears a reset cause flag; writing 0 leaves it.
// - all cause flags zero means power-on or brownout reset.
// - separate flags for pin, watchdog, software and lock-up resets.
// - flags for wake by pin sense and by debug mode entry.
// - flag for wake by bus power rising into range.
// - bank status reports two bank bits from four memory sections.
// - bank bit is 1 while any of its sections is powered.
// - writing 1 to 0x500 requests shutdown.
// - configuration bit 0 enables the supply fail warning.
// - four-bit fail level, codes 4 to 15 select 1.7 to 2.8 V.
// - separate four-bit high supply fail level, 2.7 to 4.2 V.
// - read-write scratch register at 0x51C.
// - scratch keeps its contents through resets.
//
// The Wishbone register port was decided locally.
`timescale 1ns/1ps
`default_nettype none

module psr_regs (
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    // wishbone classic slave
    input  wire logic                   cyc_i,
    input  wire logic                   stb_i,
    input  wire logic                   we_i,
    input  wire logic [11:0]            adr_i,
    input  wire logic [3:0]             sel_i,
    input  wire logic [31:0]            dat_i,
    output logic      [31:0]            dat_o,
    output logic                        ack_o,
    // hardware event pulses and cause strobes
    input  wire psr_pkg::psr_events_t   event_pulse_i,
    input  wire psr_pkg::psr_causes_t   cause_pulse_i,
    input  wire logic [3:0]             section_on_i,
    input  wire logic                   bus_power_present_i,
    input  wire logic                   regulator_output_settled_i,
    output logic                        power_irq_o,
    output logic                        shutdown_req_o,
    output psr_pkg::psr_fail_cfg_t      fail_cfg_o
);

    // ==================================================================
    // state
    logic [5:0]  event_q;
    logic [5:0]  event_d;
    logic [5:0]  irq_en_q;
    logic [5:0]  irq_en_d;
    logic [31:0] cause_q;
    logic [31:0] cause_d;
    logic [31:0] scratch_q;
    logic [31:0] scratch_d;
    logic [8:0]  cfg_q;
    logic [8:0]  cfg_d;
    logic        ack_q;
    logic [31:0] rdata_q;
    logic        shut_q;

    // ==================================================================
    // bus decode
    wire logic        req_w   = cyc_i && stb_i && !ack_q;
    wire logic        wr_w    = req_w && we_i;
    wire logic [31:0] lane_w  = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
    wire logic [31:0] wmask_d = dat_i & lane_w;

    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        hit = (a == off);
    endfunction

    // event register index from address; 7 means not an event register
    logic [2:0] ev_idx_w;
    always_comb begin
        if (hit(adr_i, psr_pkg::OFF_EV_WARN)) begin
            ev_idx_w = 3'(psr_pkg::EV_WARN);
        end else if (hit(adr_i, psr_pkg::OFF_EV_SLEEPIN)) begin
            ev_idx_w = 3'(psr_pkg::EV_SLEEPIN);
        end else if (hit(adr_i, psr_pkg::OFF_EV_SLEEPOUT)) begin
            ev_idx_w = 3'(psr_pkg::EV_SLEEPOUT);
        end else if (hit(adr_i, psr_pkg::OFF_EV_ARRIVAL)) begin
            ev_idx_w = 3'(psr_pkg::EV_ARRIVAL);
        end else if (hit(adr_i, psr_pkg::OFF_EV_LOSS)) begin
            ev_idx_w = 3'(psr_pkg::EV_LOSS);
        end else if (hit(adr_i, psr_pkg::OFF_EV_SETTLED)) begin
            ev_idx_w = 3'(psr_pkg::EV_SETTLED);
        end else begin
            ev_idx_w = 3'h7;
        end
    end

    wire logic is_ev_w    = (ev_idx_w != 3'h7);
    wire logic is_set_w   = hit(adr_i, psr_pkg::OFF_IRQ_SET);
    wire logic is_clr_w   = hit(adr_i, psr_pkg::OFF_IRQ_CLR);
    wire logic is_cause_w = hit(adr_i, psr_pkg::OFF_RST_CAUSE);
    wire logic is_bank_w  = hit(adr_i, psr_pkg::OFF_BANK_STAT);
    wire logic is_usb_w   = hit(adr_i, psr_pkg::OFF_USB_STAT);
    wire logic is_shut_w  = hit(adr_i, psr_pkg::OFF_SHUTDOWN);
    wire logic is_cfg_w   = hit(adr_i, psr_pkg::OFF_FAIL_CFG);
    wire logic is_scr_w   = hit(adr_i, psr_pkg::OFF_SCRATCH);

    wire psr_pkg::psr_events_t ev_w = event_pulse_i;
    wire logic [5:0] ev_in_w = {ev_w.regulator_settled, ev_w.supply_loss,
                                ev_w.supply_arrival, ev_w.sleep_out,
                                ev_w.sleep_in, ev_w.warn};

    // ==================================================================
    // event flags: hardware set wins over a software clear in the same cycle
    always_comb begin
        event_d = event_q;
        if (wr_w && is_ev_w && sel_i[0] && !dat_i[0]) begin
            event_d[ev_idx_w] = 1'b0;
        end
        if (wr_w && is_ev_w && sel_i[0] && dat_i[0]) begin
            event_d[ev_idx_w] = 1'b1;
        end
        event_d = event_d | ev_in_w;
    end

    // ==================================================================
    // interrupt enables
    always_comb begin
        irq_en_d = irq_en_q;
        if (wr_w && is_set_w) begin
            irq_en_d = irq_en_q | wmask_d[5:0];
        end else if (wr_w && is_clr_w) begin
            irq_en_d = irq_en_q & ~wmask_d[5:0];
        end
    end

    // ==================================================================
    // reset causes: set wins over the write-one clear
    wire psr_pkg::psr_causes_t cs_w = cause_pulse_i;
    logic [31:0] cause_set_w;
    always_comb begin
        cause_set_w = psr_pkg::RESET_WORD;
        cause_set_w[psr_pkg::RC_PIN]       = cs_w.pin;
        cause_set_w[psr_pkg::RC_WATCHDOG]  = cs_w.watchdog;
        cause_set_w[psr_pkg::RC_SOFTWARE]  = cs_w.software;
        cause_set_w[psr_pkg::RC_LOCKUP]    = cs_w.lockup;
        cause_set_w[psr_pkg::RC_PIN_SENSE] = cs_w.pin_sense_wake;
        cause_set_w[psr_pkg::RC_DEBUG]     = cs_w.debug_wake;
        cause_set_w[psr_pkg::RC_BUS_POWER] = cs_w.bus_power_wake;
    end

    wire logic [31:0] cause_clr_w = (wr_w && is_cause_w) ? wmask_d : psr_pkg::RESET_WORD;
    // power-on or brownout leave every flag clear, so all-zero reads as that case
    assign cause_d = ((cause_q & ~cause_clr_w) | cause_set_w) & psr_pkg::RC_MASK;

    // ==================================================================
    // configuration and scratch
    assign cfg_d = (wr_w && is_cfg_w) ?
                   {wmask_d[psr_pkg::CFG_HIGH_LSB +: psr_pkg::LEVEL_W],
                    wmask_d[psr_pkg::CFG_LEVEL_LSB +: psr_pkg::LEVEL_W],
                    wmask_d[psr_pkg::CFG_ENABLE_BIT]} : cfg_q;

    // byte lanes keep unselected bytes
    assign scratch_d = (wr_w && is_scr_w) ?
                       ((scratch_q & ~lane_w) | (dat_i & lane_w)) : scratch_q;

    // ==================================================================
    // read mux
    wire logic [1:0] bank_w = {section_on_i[2] | section_on_i[3],
                               section_on_i[0] | section_on_i[1]};
    logic [31:0] rd_w;
    always_comb begin
        rd_w = psr_pkg::RESET_WORD;
        if (is_ev_w) begin
            rd_w[0] = event_q[ev_idx_w];
        end else if (is_set_w || is_clr_w) begin
            rd_w[5:0] = irq_en_q;
        end else if (is_cause_w) begin
            rd_w = cause_q;
        end else if (is_bank_w) begin
            rd_w[1:0] = bank_w;
        end else if (is_usb_w) begin
            rd_w[1:0] = {regulator_output_settled_i, bus_power_present_i};
        end else if (is_cfg_w) begin
            rd_w[psr_pkg::CFG_ENABLE_BIT] = cfg_q[0];
            rd_w[psr_pkg::CFG_LEVEL_LSB +: psr_pkg::LEVEL_W] = cfg_q[4:1];
            rd_w[psr_pkg::CFG_HIGH_LSB +: psr_pkg::LEVEL_W]  = cfg_q[8:5];
        end else if (is_scr_w) begin
            rd_w = scratch_q;
        end
    end

    // ==================================================================
    // registers cleared by system reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            event_q  <= 6'h00;
            irq_en_q <= 6'h00;
            cfg_q    <= 9'h000;
            ack_q    <= 1'b0;
            rdata_q  <= psr_pkg::RESET_WORD;
            shut_q   <= 1'b0;
        end else begin
            event_q  <= event_d;
            irq_en_q <= irq_en_d;
            cfg_q    <= cfg_d;
            ack_q    <= req_w;
            rdata_q  <= req_w ? rd_w : psr_pkg::RESET_WORD;
            shut_q   <= wr_w && is_shut_w && sel_i[0] && dat_i[0];
        end
    end

    // causes and scratch survive system reset; the strobes that mark a reset
    // arrive while rst_i is high, so they must still be captured then
    always_ff @(posedge clk_i) begin
        cause_q   <= rst_i ? ((cause_q | cause_set_w) & psr_pkg::RC_MASK) : cause_d;
        scratch_q <= scratch_d;
    end

    // ==================================================================
    // outputs
    assign ack_o          = ack_q;
    assign dat_o          = rdata_q;
    assign power_irq_o    = |(event_q & irq_en_q);
    assign shutdown_req_o = shut_q;
    assign fail_cfg_o     = '{enable: cfg_q[0], level: cfg_q[4:1], high_level: cfg_q[8:5]};

    // ==================================================================
    // checks
    chk_irq_follows: assert property (@(posedge clk_i) disable iff (rst_i)
        event_q[psr_pkg::EV_LOSS] && irq_en_q[psr_pkg::EV_LOSS] |-> power_irq_o)
        else $error("irq missing for enabled flag");
    chk_irq_no_flag: assert property (@(posedge clk_i) disable iff (rst_i)
        !(|event_q) |-> !power_irq_o)
        else $error("irq without any flag");
    chk_arrival_set: assert property (@(posedge clk_i) disable iff (rst_i)
        ev_w.supply_arrival |=> event_q[psr_pkg::EV_ARRIVAL])
        else $error("arrival flag not set");
    chk_loss_set: assert property (@(posedge clk_i) disable iff (rst_i)
        ev_w.supply_loss |=> event_q[psr_pkg::EV_LOSS])
        else $error("loss flag not set");
    chk_settle_set: assert property (@(posedge clk_i) disable iff (rst_i)
        ev_w.regulator_settled |=> event_q[psr_pkg::EV_SETTLED])
        else $error("settled flag not set");
    chk_enable_set: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_w && is_set_w && sel_i[0] && dat_i[0] |=> irq_en_q[0])
        else $error("enable set write lost");
    chk_enable_clr: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_w && is_clr_w && sel_i[0] && dat_i[0] |=> !irq_en_q[0])
        else $error("enable clear write lost");
    chk_cause_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        cause_q[psr_pkg::RC_PIN] && !(wr_w && is_cause_w && sel_i[0] && dat_i[0])
        |=> cause_q[psr_pkg::RC_PIN])
        else $error("cause flag dropped without clear");
    chk_cause_w1c: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_w && is_cause_w && sel_i[0] && dat_i[psr_pkg::RC_WATCHDOG] && !cs_w.watchdog
        |=> !cause_q[psr_pkg::RC_WATCHDOG])
        else $error("cause flag not cleared by one");
    chk_bank_or: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_q && !we_i && $past(is_bank_w && req_w) |-> dat_o[1:0] == $past(bank_w))
        else $error("bank status wrong");
    chk_shutdown_req: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_w && is_shut_w && sel_i[0] && dat_i[0] |=> shutdown_req_o ##1 !shutdown_req_o)
        else $error("shutdown pulse wrong");
    chk_scratch_keep: assert property (@(posedge clk_i)
        !(wr_w && is_scr_w) |=> scratch_q === $past(scratch_q))
        else $error("scratch changed without write");
    chk_warn_set: assert property (@(posedge clk_i) disable iff (rst_i)
        ev_w.warn |=> event_q[psr_pkg::EV_WARN])
        else $error("warning flag not set");
    chk_sleepin_set: assert property (@(posedge clk_i) disable iff (rst_i)
        ev_w.sleep_in |=> event_q[psr_pkg::EV_SLEEPIN])
        else $error("sleep entry flag not set");
    chk_sleepout_set: assert property (@(posedge clk_i) disable iff (rst_i)
        ev_w.sleep_out |=> event_q[psr_pkg::EV_SLEEPOUT])
        else $error("sleep exit flag not set");
    chk_flag_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_w && ev_idx_w == 3'(psr_pkg::EV_LOSS) && sel_i[0] && !dat_i[0]
        && !ev_w.supply_loss |=> !event_q[psr_pkg::EV_LOSS])
        else $error("flag not cleared by zero");
    chk_flag_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        event_q[psr_pkg::EV_ARRIVAL] && !(wr_w && is_ev_w) |=> event_q[psr_pkg::EV_ARRIVAL])
        else $error("arrival flag dropped");
    chk_irq_no_enable: assert property (@(posedge clk_i) disable iff (rst_i)
        !(|irq_en_q) |-> !power_irq_o)
        else $error("irq without any enable");
    chk_enable_keep: assert property (@(posedge clk_i) disable iff (rst_i)
        !(wr_w && (is_set_w || is_clr_w)) |=> $stable(irq_en_q))
        else $error("enables changed without write");
    chk_set_adds: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_w && is_set_w |=> (irq_en_q & $past(irq_en_q)) == $past(irq_en_q))
        else $error("set write dropped an enable");
    chk_clr_drops: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_w && is_clr_w |=> (irq_en_q | $past(irq_en_q)) == $past(irq_en_q))
        else $error("clear write raised an enable");
    chk_enable_read: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_q && !we_i && $past(req_w && is_clr_w) |-> dat_o[5:0] == $past(irq_en_q))
        else $error("enable readback wrong");
    chk_pin_cause: assert property (@(posedge clk_i)
        cs_w.pin |=> cause_q[psr_pkg::RC_PIN])
        else $error("pin cause not set");
    chk_dog_cause: assert property (@(posedge clk_i)
        cs_w.watchdog |=> cause_q[psr_pkg::RC_WATCHDOG])
        else $error("watchdog cause not set");
    chk_soft_cause: assert property (@(posedge clk_i)
        cs_w.software |=> cause_q[psr_pkg::RC_SOFTWARE])
        else $error("software cause not set");
    chk_lockup_cause: assert property (@(posedge clk_i)
        cs_w.lockup |=> cause_q[psr_pkg::RC_LOCKUP])
        else $error("lockup cause not set");
    chk_sense_cause: assert property (@(posedge clk_i)
        cs_w.pin_sense_wake |=> cause_q[psr_pkg::RC_PIN_SENSE])
        else $error("pin sense cause not set");
    chk_debug_cause: assert property (@(posedge clk_i)
        cs_w.debug_wake |=> cause_q[psr_pkg::RC_DEBUG])
        else $error("debug cause not set");
    chk_bus_cause: assert property (@(posedge clk_i)
        cs_w.bus_power_wake |=> cause_q[psr_pkg::RC_BUS_POWER])
        else $error("bus power cause not set");
    chk_cause_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_w && is_cause_w && dat_i == 32'h0 && !(|cs_w) |=> cause_q == $past(cause_q))
        else $error("zero write changed causes");
    chk_cause_reserved: assert property (@(posedge clk_i) disable iff (rst_i)
        (cause_q & ~psr_pkg::RC_MASK) == 32'h0)
        else $error("reserved cause bit set");
    chk_cause_read: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_q && !we_i && $past(req_w && is_cause_w) |-> dat_o == $past(cause_q))
        else $error("cause readback wrong");
    chk_bank0_on: assert property (@(posedge clk_i) disable iff (rst_i)
        section_on_i[1] |-> bank_w[0])
        else $error("bank 0 not on");
    chk_bank1_on: assert property (@(posedge clk_i) disable iff (rst_i)
        section_on_i[3] |-> bank_w[1])
        else $error("bank 1 not on");
    chk_shut_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_w && is_shut_w && !dat_i[0] |=> !shutdown_req_o)
        else $error("shutdown on zero write");
    chk_shut_idle: assert property (@(posedge clk_i) disable iff (rst_i)
        !(wr_w && is_shut_w) |=> !shutdown_req_o)
        else $error("shutdown without write");
    chk_cfg_enable: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_w && is_cfg_w && sel_i[0] |=> fail_cfg_o.enable == $past(dat_i[0]))
        else $error("enable bit not stored");
    chk_cfg_level: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_w && is_cfg_w && sel_i[0] |=> fail_cfg_o.level == $past(dat_i[4:1]))
        else $error("fail level not stored");
    chk_cfg_high: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_w && is_cfg_w && sel_i[1] |=> fail_cfg_o.high_level == $past(dat_i[11:8]))
        else $error("high level not stored");
    chk_cfg_keep: assert property (@(posedge clk_i) disable iff (rst_i)
        !(wr_w && is_cfg_w) |=> $stable(fail_cfg_o))
        else $error("config changed without write");
    chk_scratch_write: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_w && is_scr_w && sel_i == 4'hF |=> scratch_q == $past(dat_i))
        else $error("scratch write lost");
    chk_scratch_read: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_q && !we_i && $past(req_w && is_scr_w) |-> dat_o == $past(scratch_q))
        else $error("scratch readback wrong");
    chk_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    chk_ack_follows: assert property (@(posedge clk_i) disable iff (rst_i)
        cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("request not acknowledged");
    chk_idle_data: assert property (@(posedge clk_i) disable iff (rst_i)
        !ack_o |-> dat_o == 32'h0)
        else $error("read data outside ack");
    chk_usb_read: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_q && !we_i && $past(req_w && is_usb_w)
        |-> dat_o[1:0] == $past({regulator_output_settled_i, bus_power_present_i}))
        else $error("usb status readback wrong");
    chk_unmapped_read: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_q && !we_i && $past(req_w) && $past(adr_i) == 12'h7F0 |-> dat_o == 32'h0)
        else $error("unmapped read not zero");

endmodule // psr_regs

`default_nettype wire

// >>> psr_pkg.sv
// package for the power supervisor register bank: map, fields, carriers
package psr_pkg;

    // ==================================================================
    // register byte offsets
    localparam logic [11:0] OFF_EV_WARN     = 12'h108;
    localparam logic [11:0] OFF_EV_SLEEPIN  = 12'h114;
    localparam logic [11:0] OFF_EV_SLEEPOUT = 12'h118;
    localparam logic [11:0] OFF_EV_ARRIVAL  = 12'h11C;
    localparam logic [11:0] OFF_EV_LOSS     = 12'h120;
    localparam logic [11:0] OFF_EV_SETTLED  = 12'h124;
    localparam logic [11:0] OFF_IRQ_SET     = 12'h304;
    localparam logic [11:0] OFF_IRQ_CLR     = 12'h308;
    localparam logic [11:0] OFF_RST_CAUSE   = 12'h400;
    localparam logic [11:0] OFF_BANK_STAT   = 12'h428;
    localparam logic [11:0] OFF_USB_STAT    = 12'h438;
    localparam logic [11:0] OFF_SHUTDOWN    = 12'h500;
    localparam logic [11:0] OFF_FAIL_CFG    = 12'h510;
    localparam logic [11:0] OFF_SCRATCH     = 12'h51C;

    // ==================================================================
    // field layout
    localparam int NUM_EVENTS        = 6;
    localparam int EV_WARN           = 0;
    localparam int EV_SLEEPIN        = 1;
    localparam int EV_SLEEPOUT       = 2;
    localparam int EV_ARRIVAL        = 3;
    localparam int EV_LOSS           = 4;
    localparam int EV_SETTLED        = 5;
    // reset cause bit positions
    localparam int RC_PIN            = 0;
    localparam int RC_WATCHDOG       = 1;
    localparam int RC_SOFTWARE       = 2;
    localparam int RC_LOCKUP         = 3;
    localparam int RC_PIN_SENSE      = 16;
    localparam int RC_DEBUG          = 18;
    localparam int RC_BUS_POWER      = 20;
    localparam logic [31:0] RC_MASK  = 32'h0015000F;
    // comparator configuration
    localparam int CFG_ENABLE_BIT    = 0;
    localparam int CFG_LEVEL_LSB     = 1;
    localparam int CFG_HIGH_LSB      = 8;
    localparam int LEVEL_W           = 4;
    localparam logic [31:0] CFG_MASK = 32'h00000F1F;
    localparam logic [3:0] LEVEL_MIN_USABLE = 4'h4;

    // ==================================================================
    // reset values
    localparam logic [31:0] RESET_WORD = 32'h00000000;

    // ==================================================================
    // carriers
    typedef struct packed {
        logic       warn;
        logic       sleep_in;
        logic       sleep_out;
        logic       supply_arrival;
        logic       supply_loss;
        logic       regulator_settled;
    } psr_events_t;

    typedef struct packed {
        logic       pin;
        logic       watchdog;
        logic       software;
        logic       lockup;
        logic       pin_sense_wake;
        logic       debug_wake;
        logic       bus_power_wake;
    } psr_causes_t;

    typedef struct packed {
        logic       enable;
        logic [3:0] level;
        logic [3:0] high_level;
    } psr_fail_cfg_t;

endpackage

// >>> tb_psr_regs.sv
// self-checking bench for the power supervisor register bank
`timescale 1ns/1ps
`default_nettype none

module tb_psr_regs;
    // ==================================================================
    // stimulus and observation
    logic                   clk_i, rst_i, cyc_i, stb_i, we_i, ack_o;
    logic                   bus_power_present_i, regulator_output_settled_i;
    logic                   power_irq_o, shutdown_req_o;
    logic [11:0]            adr_i;
    logic [3:0]             sel_i, section_on_i;
    logic [31:0]            dat_i, dat_o, rdata;
    psr_pkg::psr_events_t   event_pulse_i;
    psr_pkg::psr_causes_t   cause_pulse_i;
    psr_pkg::psr_fail_cfg_t fail_cfg_o;
    int                     num_errors, comparisons, sd_cnt, n0;
    logic [3:0]             l;
    logic [11:0]            ev_off [6] = '{psr_pkg::OFF_EV_WARN, psr_pkg::OFF_EV_SLEEPIN,
        psr_pkg::OFF_EV_SLEEPOUT, psr_pkg::OFF_EV_ARRIVAL, psr_pkg::OFF_EV_LOSS,
        psr_pkg::OFF_EV_SETTLED};
    int                     rc_pos [7] = '{psr_pkg::RC_PIN, psr_pkg::RC_WATCHDOG,
        psr_pkg::RC_SOFTWARE, psr_pkg::RC_LOCKUP, psr_pkg::RC_PIN_SENSE,
        psr_pkg::RC_DEBUG, psr_pkg::RC_BUS_POWER};

    psr_regs dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .event_pulse_i(event_pulse_i), .cause_pulse_i(cause_pulse_i),
        .section_on_i(section_on_i), .bus_power_present_i(bus_power_present_i),
        .regulator_output_settled_i(regulator_output_settled_i),
        .power_irq_o(power_irq_o), .shutdown_req_o(shutdown_req_o), .fail_cfg_o(fail_cfg_o));

    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        if (shutdown_req_o === 1'b1) begin
            sd_cnt++;
        end
    end

    // ==================================================================
    // helpers
    task automatic conclude();
        $display("mismatches %0d, comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // classic cycle: request held until ack is sampled, then one idle cycle
    task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        rdata = dat_o;
        chk(32'(ack_o), 32'h1);
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i  <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        chk(rdata, exp);
    endtask

    task automatic pulse(input int ev, input int cs);
        event_pulse_i <= psr_pkg::psr_events_t'(6'h20 >> ev);
        cause_pulse_i <= psr_pkg::psr_causes_t'(7'h40 >> cs);
        @(posedge clk_i);
        event_pulse_i <= '0;
        cause_pulse_i <= '0;
        @(posedge clk_i);
    endtask

    // irq is combinational from registers: let the edge's updates land first
    task automatic chk_irq(input logic exp);
        #1 chk(32'(power_irq_o), 32'(exp));
        @(posedge clk_i);
    endtask

    // ==================================================================
    // tests
    initial begin
        {cyc_i, stb_i, we_i, adr_i, dat_i, section_on_i} = '0;
        {bus_power_present_i, regulator_output_settled_i} = 2'b00;
        {event_pulse_i, cause_pulse_i, num_errors, comparisons, sd_cnt} = '0;
        sel_i = 4'hF;
        rst_i = 1'b1;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(psr_pkg::OFF_IRQ_SET, 32'h0);
        rd(psr_pkg::OFF_FAIL_CFG, 32'h0);
        for (int i = 0; i < 6; i++) begin
            pulse(i, 7);
            chk_irq(1'b0);
            rd(ev_off[i], 32'h1);
            wb(1'b1, ev_off[i], 32'h0);
            rd(ev_off[i], 32'h0);
        end
        wb(1'b1, psr_pkg::OFF_IRQ_SET, 32'hFFFFFFFF);
        rd(psr_pkg::OFF_IRQ_CLR, 32'h3F);
        wb(1'b1, psr_pkg::OFF_IRQ_CLR, 32'h05);
        rd(psr_pkg::OFF_IRQ_SET, 32'h3A);
        rd(psr_pkg::OFF_IRQ_CLR, 32'h3A);
        pulse(0, 7);
        chk_irq(1'b0);
        pulse(1, 7);
        chk_irq(1'b1);
        wb(1'b1, ev_off[1], 32'h0);
        chk_irq(1'b0);
        wb(1'b1, ev_off[0], 32'h0);
        wb(1'b1, psr_pkg::OFF_RST_CAUSE, 32'hFFFFFFFF);
        rd(psr_pkg::OFF_RST_CAUSE, 32'h0);
        for (int j = 0; j < 7; j++) begin
            pulse(6, j);
            rd(psr_pkg::OFF_RST_CAUSE, 32'h1 << rc_pos[j]);
            wb(1'b1, psr_pkg::OFF_RST_CAUSE, 32'h1 << rc_pos[j]);
            rd(psr_pkg::OFF_RST_CAUSE, 32'h0);
        end
        pulse(6, 0);
        rst_i <= 1'b1;
        pulse(6, 1);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(psr_pkg::OFF_RST_CAUSE, 32'h3);
        wb(1'b1, psr_pkg::OFF_RST_CAUSE, 32'h0);
        rd(psr_pkg::OFF_RST_CAUSE, 32'h3);
        wb(1'b1, psr_pkg::OFF_RST_CAUSE, 32'h2);
        rd(psr_pkg::OFF_RST_CAUSE, 32'h1);
        for (int k = 0; k < 16; k++) begin
            section_on_i <= 4'(k);
            @(posedge clk_i);
            rd(psr_pkg::OFF_BANK_STAT, {30'h0, |k[3:2], |k[1:0]});
        end
        {bus_power_present_i, regulator_output_settled_i} <= 2'b10;
        @(posedge clk_i);
        rd(psr_pkg::OFF_USB_STAT, 32'h1);
        n0 = sd_cnt;
        wb(1'b1, psr_pkg::OFF_SHUTDOWN, 32'h0);
        repeat (2) @(posedge clk_i);
        chk(32'(sd_cnt), 32'(n0));
        wb(1'b1, psr_pkg::OFF_SHUTDOWN, 32'h1);
        repeat (2) @(posedge clk_i);
        chk(32'(sd_cnt), 32'(n0 + 1));
        rd(psr_pkg::OFF_SHUTDOWN, 32'h0);
        // only usable fail levels are programmed
        for (int k = 4; k < 16; k++) begin
            l = 4'(k);
            wb(1'b1, psr_pkg::OFF_FAIL_CFG, {20'h0, l - 4'h4, 3'h0, l, l[0]});
            chk(32'(fail_cfg_o), 32'({l[0], l, l - 4'h4}));
            rd(psr_pkg::OFF_FAIL_CFG, {20'h0, l - 4'h4, 3'h0, l, l[0]});
        end
        wb(1'b1, psr_pkg::OFF_FAIL_CFG, 32'hFFFFFFFF);
        rd(psr_pkg::OFF_FAIL_CFG, psr_pkg::CFG_MASK);
        wb(1'b1, 12'h7F0, 32'hFFFFFFFF);
        rd(12'h7F0, 32'h0);
        wb(1'b1, psr_pkg::OFF_SCRATCH, 32'hA5C30F96);
        rd(psr_pkg::OFF_SCRATCH, 32'hA5C30F96);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(psr_pkg::OFF_SCRATCH, 32'hA5C30F96);
        rd(psr_pkg::OFF_IRQ_SET, 32'h0);
        chk(32'(fail_cfg_o), 32'h0);
        conclude();
    end

    // the sequence needs a few hundred cycles; 20000 means a hang
    initial begin
        repeat (20000) @(posedge clk_i);
        num_errors++;
        conclude();
    end
endmodule // tb_psr_regs

`default_nettype wire
